// file: hw/pair_timers.sv
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "timer_map.svh"

// Function
// - Join bit merges pair into 32-bit timer
// - Split pair offers all synchronous modes
// - Lower holds low word, upper high
// - Joined mode ignores upper control register
// - Lower clock/gate drive; upper flag signals
// - Period high word from upper register
// - 32-bit period match raises interrupt
// - Gate accumulates only with internal clock
// - Prescale divides by 1, 8, 64, 256
// - Clock source selects pin edge or internal
// - Each timer synchronous timer or counter
// - Pairs one/two trigger converters one/two
// - Only first pair requests memory transfers
// - Only first pair feeds capture time base
module pair_timers (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // Register port
    input  wire timer_pkg::bus_req_t bus_req,
    output logic [15:0]            rdata,
    // Pins and system state
    input  wire logic [7:0]        external_clock_pin,
    input  wire logic              cpu_idle,
    // Events and time base
    output logic                   irq,
    output logic                   adc1_trigger,
    output logic                   adc2_trigger,
    output logic                   dma_request,
    output logic [15:0]            timebase_lower,
    output logic [15:0]            timebase_upper
);
    import timer_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Storage

    ctrl_t       ctrl_r   [8];
    logic [15:0] count_r  [8];
    logic [15:0] period_r [8];
    logic [7:0]  pre_r    [8];
    logic [7:0]  status_r;
    logic [7:0]  enable_r;
    logic [15:0] rdata_r;
    logic        adc1_r;
    logic        adc2_r;
    logic        dma_r;
    logic [7:0]  pin_s1_r;
    logic [7:0]  pin_s2_r;
    logic [7:0]  pin_s3_r;

    logic [15:0] count_nxt [8];
    logic [7:0]  run;
    logic [7:0]  src;
    logic [7:0]  tick;
    logic [7:0]  match_ev;
    logic [3:0]  joined;
    logic        win_hit;
    logic [2:0]  win_idx;
    logic [1:0]  win_ofs;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [7:0] ps_last(input logic [1:0] ps);
        case (prescale_t'(ps))
            PS_DIV8:   ps_last = `PS_LAST_8;
            PS_DIV64:  ps_last = `PS_LAST_64;
            PS_DIV256: ps_last = `PS_LAST_256;
            default:   ps_last = `PS_LAST_1;
        endcase
    endfunction

    function automatic logic [15:0] ctrl_mask(input logic upper);
        ctrl_mask = upper ? `CTRL_UPPER_MASK : `CTRL_LOWER_MASK;
    endfunction

    assign win_hit = (bus_req.addr[7:5] == 3'h0) && (bus_req.addr[1:0] != 2'h3);
    assign win_idx = bus_req.addr[4:2];
    assign win_ofs = bus_req.addr[1:0];

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the gate and the external clock share the same pin.

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1_r <= 8'h00;
            pin_s2_r <= 8'h00;
            pin_s3_r <= 8'h00;
        end else begin
            pin_s1_r <= external_clock_pin;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock selection, gating and prescaler

    always_comb begin
        for (int p = 0; p < 4; p++) begin
            joined[p] = ctrl_r[2*p].pair_join;
        end
        for (int i = 0; i < 8; i++) begin
            run[i] = ctrl_r[i].timer_on && !(cpu_idle && ctrl_r[i].stop_in_idle)
                     && !((i % 2 == 1) && joined[i/2]);
            if (ctrl_r[i].clock_source_select) begin
                src[i] = pin_s2_r[i] && !pin_s3_r[i];
            end else if (ctrl_r[i].gate_accumulate_enable) begin
                src[i] = pin_s2_r[i];
            end else begin
                src[i] = 1'b1;
            end
            // A prescaler left above a newly lowered terminal count ticks at once, not after wrap.
            tick[i] = run[i] && src[i] && (pre_r[i] >= ps_last(ctrl_r[i].prescale_select));
        end
    end

    // The prescaler restarts whenever its timer stops, so a fresh start divides exactly.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 8; i++) begin
                pre_r[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (!run[i]) begin
                    pre_r[i] <= 8'h00;
                end else if (src[i]) begin
                    if (pre_r[i] >= ps_last(ctrl_r[i].prescale_select)) begin
                        pre_r[i] <= 8'h00;
                    end else begin
                        pre_r[i] <= pre_r[i] + 8'h01;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counters and period match

    always_comb begin
        logic [31:0] wide;
        logic [31:0] wide_per;
        wide     = 32'h0;
        wide_per = 32'h0;
        match_ev = 8'h00;
        for (int i = 0; i < 8; i++) begin
            count_nxt[i] = count_r[i];
        end
        for (int p = 0; p < 4; p++) begin
            // low word lower, high word upper
            wide     = {count_r[2*p+1], count_r[2*p]};
            wide_per = {period_r[2*p+1], period_r[2*p]};
            if (joined[p]) begin
                if (tick[2*p]) begin
                    if (wide == wide_per) begin
                        wide              = 32'h0;
                        match_ev[2*p+1]   = 1'b1;
                    end else begin
                        wide = wide + 32'h1;
                    end
                    count_nxt[2*p]   = wide[15:0];
                    count_nxt[2*p+1] = wide[31:16];
                end
            end else begin
                for (int k = 0; k < 2; k++) begin
                    if (tick[2*p+k]) begin
                        if (count_r[2*p+k] == period_r[2*p+k]) begin
                            count_nxt[2*p+k] = 16'h0000;
                            match_ev[2*p+k]  = 1'b1;
                        end else begin
                            count_nxt[2*p+k] = count_r[2*p+k] + 16'h0001;
                        end
                    end
                end
            end
        end
    end

    // A software write to a count register wins over a tick in the same cycle.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 8; i++) begin
                count_r[i] <= `COUNT_RESET;
            end
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (bus_req.wr && win_hit && win_idx == 3'(i) && win_ofs == `TMR_COUNT_OFS) begin
                    count_r[i] <= bus_req.wdata;
                end else begin
                    count_r[i] <= count_nxt[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control and period registers

    // counting starts only once timer_on is written, after setup.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 8; i++) begin
                ctrl_r[i]   <= ctrl_t'(`CTRL_RESET);
                period_r[i] <= `PERIOD_RESET;
            end
        end else if (bus_req.wr && win_hit) begin
            if (win_ofs == `TMR_CTRL_OFS) begin
                ctrl_r[win_idx] <= ctrl_t'(bus_req.wdata & ctrl_mask(win_idx[0]));
            end
            if (win_ofs == `TMR_PERIOD_OFS) begin
                period_r[win_idx] <= bus_req.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status, enable and clear

    // A match in the cycle of its clear keeps the flag set.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_r <= `IRQ_RESET;
        end else if (bus_req.wr && bus_req.addr == `IRQ_CLEAR_ADDR) begin
            status_r <= (status_r & ~bus_req.wdata[7:0]) | match_ev;
        end else begin
            status_r <= status_r | match_ev;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            enable_r <= `IRQ_RESET;
        end else if (bus_req.wr && bus_req.addr == `IRQ_ENABLE_ADDR) begin
            enable_r <= bus_req.wdata[7:0];
        end
    end

    assign irq = |(status_r & enable_r);

    ////////////////////////////////////////////////////////////////////////////////
    // Trigger outputs

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            adc1_r <= 1'b0;
            adc2_r <= 1'b0;
            dma_r  <= 1'b0;
        end else begin
            adc1_r <= match_ev[1];
            adc2_r <= match_ev[3];
            dma_r  <= match_ev[0] | match_ev[1];
        end
    end

    assign adc1_trigger = adc1_r;
    assign adc2_trigger = adc2_r;
    assign dma_request  = dma_r;

    assign timebase_lower = count_r[0];
    assign timebase_upper = count_r[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Read data, valid only in the cycle after the read strobe

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 16'h0000;
        end else if (!bus_req.rd) begin
            rdata_r <= 16'h0000;
        end else if (win_hit) begin
            case (win_ofs)
                `TMR_CTRL_OFS:   rdata_r <= 16'(ctrl_r[win_idx]);
                `TMR_COUNT_OFS:  rdata_r <= count_r[win_idx];
                `TMR_PERIOD_OFS: rdata_r <= period_r[win_idx];
                default:         rdata_r <= 16'h0000;
            endcase
        end else if (bus_req.addr == `IRQ_STATUS_ADDR) begin
            rdata_r <= {8'h00, status_r};
        end else if (bus_req.addr == `IRQ_ENABLE_ADDR) begin
            rdata_r <= {8'h00, enable_r};
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    assign rdata = rdata_r;

endmodule

// file: inc/timer_map.svh
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// Per-timer window: timer n occupies word addresses n*4 .. n*4+3.
`define TMR_CTRL_OFS      2'h0
`define TMR_COUNT_OFS     2'h1
`define TMR_PERIOD_OFS    2'h2

// Interrupt registers above the timer windows.
`define IRQ_STATUS_ADDR   8'h20
`define IRQ_CLEAR_ADDR    8'h21
`define IRQ_ENABLE_ADDR   8'h22

// Writable bits of the two control register flavours.
`define CTRL_LOWER_MASK   16'hA07A
`define CTRL_UPPER_MASK   16'hA072

// Reset values.
`define CTRL_RESET        16'h0000
`define COUNT_RESET       16'h0000
`define PERIOD_RESET      16'hFFFF
`define IRQ_RESET         8'h00

// Terminal prescaler counts for the four ratios.
`define PS_LAST_1         8'h00
`define PS_LAST_8         8'h07
`define PS_LAST_64        8'h3F
`define PS_LAST_256       8'hFF

`endif

// file: inc/timer_pkg.sv
package timer_pkg;

    typedef struct packed {
        logic       timer_on;
        logic       rsv14;
        logic       stop_in_idle;
        logic [5:0] rsv12_7;
        logic       gate_accumulate_enable;
        logic [1:0] prescale_select;
        logic       pair_join;
        logic       rsv2;
        logic       clock_source_select;
        logic       rsv0;
    } ctrl_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    typedef enum logic [1:0] {
        PS_DIV1   = 2'h0,
        PS_DIV8   = 2'h1,
        PS_DIV64  = 2'h2,
        PS_DIV256 = 2'h3
    } prescale_t;

endpackage

// file: sim/pair_timers_asserts.sv
`timescale 1ns/1ps
`include "timer_map.svh"
module pair_timers_asserts (
    // Clock and reset
    input wire logic                clk,
    input wire logic                rstn,
    // Register port
    input wire timer_pkg::bus_req_t bus_req,
    input wire logic [15:0]         rdata,
    // Pins and system state
    input wire logic [7:0]          external_clock_pin,
    input wire logic                cpu_idle,
    // Events and time base
    input wire logic                irq,
    input wire logic                adc1_trigger,
    input wire logic                adc2_trigger,
    input wire logic                dma_request,
    input wire logic [15:0]         timebase_lower,
    input wire logic [15:0]         timebase_upper
);
    import timer_pkg::*;
    logic unmapped_a;
    assign unmapped_a = bus_req.addr == `IRQ_CLEAR_ADDR || bus_req.addr > `IRQ_ENABLE_ADDR
                        || (bus_req.addr < `IRQ_STATUS_ADDR && bus_req.addr[1:0] == 2'h3);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    sequence quiet_bus;
        !bus_req.wr ##1 !bus_req.wr;
    endsequence
    sequence ctrl_read;
        bus_req.rd && bus_req.addr < `IRQ_STATUS_ADDR && bus_req.addr[1:0] == 2'h0;
    endsequence
    // A count write lands at its own edge, so the time base shows it in the next cycle.
    property p_word(a, tb);
        logic [15:0] d;
        (bus_req.wr && bus_req.addr == a, d = bus_req.wdata) |=> tb == d;
    endproperty
    ////////////////////////////////////////////////////////////////////////////////
    AST_UNMAPPED: assert property (bus_req.rd && unmapped_a |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    AST_CTRL_RSV: assert property (ctrl_read |=> (rdata & ~($past(bus_req.addr[2]) ?
        `CTRL_UPPER_MASK : `CTRL_LOWER_MASK)) == 16'h0000)
        else $error("reserved control bit read as one");
    AST_STATUS_HI: assert property (bus_req.rd && bus_req.addr == `IRQ_STATUS_ADDR
        |=> rdata[15:8] == 8'h00) else $error("status upper byte set");
    AST_IRQ_MASK: assert property (bus_req.wr && bus_req.addr == `IRQ_ENABLE_ADDR
        && bus_req.wdata[7:0] == 8'h00 |=> !irq) else $error("irq with all enables off");
    AST_LOW_WORD: assert property (p_word(8'h01, timebase_lower))
        else $error("lower time base ignores count write");
    AST_HIGH_WORD: assert property (p_word(8'h05, timebase_upper))
        else $error("upper time base ignores count write");
    AST_TB_STEP: assert property (quiet_bus |=> timebase_lower == $past(timebase_lower)
        || timebase_lower == $past(timebase_lower) + 16'h0001 || timebase_lower == 16'h0000)
        else $error("time base jumped");
    AST_DMA_ADC1: assert property (adc1_trigger |-> dma_request)
        else $error("first pair match without transfer request");
endmodule

// file: sim/tb_pair_timers.sv
`timescale 1ns/1ps
module tb_pair_timers;
    import timer_pkg::*;
    logic                clk;
    logic                rstn;
    bus_req_t            bus_req;
    logic [15:0]         rdata;
    logic [15:0]         timebase_lower;
    logic [15:0]         timebase_upper;
    logic [15:0]         t0;
    logic [7:0]          external_clock_pin;
    logic                cpu_idle;
    logic                irq;
    logic                adc1_trigger;
    logic                adc2_trigger;
    logic                dma_request;
    int                  mismatches;
    int                  cmp_count;
    int                  n_adc1;
    int                  n_adc2;
    int                  n_dma;
    int                  n;
    int                  m;
    int                  div[4] = '{1, 8, 64, 256};

    pair_timers pair_timers_i (.clk(clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
        .external_clock_pin(external_clock_pin), .cpu_idle(cpu_idle), .irq(irq),
        .adc1_trigger(adc1_trigger), .adc2_trigger(adc2_trigger), .dma_request(dma_request),
        .timebase_lower(timebase_lower), .timebase_upper(timebase_upper));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        n_adc1 <= n_adc1 + int'(adc1_trigger === 1'b1);
        n_adc2 <= n_adc2 + int'(adc2_trigger === 1'b1);
        n_dma  <= n_dma + int'(dma_request === 1'b1);
    end
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        bus_req.wr    <= 1'b1;
        @(posedge clk);
        bus_req.wr <= 1'b0;
        #1;
    endtask
    task rdchk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        bus_req.addr <= a;
        bus_req.rd   <= 1'b1;
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task pin(input logic [7:0] p);
        @(posedge clk);
        external_clock_pin <= p;
        cyc(3);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_regs;
        rdchk(8'h00, 16'h0000);
        rdchk(8'h02, 16'hFFFF);
        wr(8'h04, 16'hFFFF);
        rdchk(8'h04, 16'hA072);
        wr(8'h04, 16'h0000);
        wr(8'h03, 16'h1234);
        rdchk(8'h03, 16'h0000);
        rdchk(8'h21, 16'h0000);
    endtask
    task t_prescale;
        for (int ps = 0; ps < 4; ps++) begin
            wr(8'h00, 16'h0000);
            wr(8'h00, 16'h8000 | 16'(ps << 4));
            cyc(4);
            t0 = timebase_lower;
            cyc(4 * div[ps]);
            chk(timebase_lower - t0, 16'h0004);
        end
    endtask
    task t_gate;
        wr(8'h00, 16'h8040);
        cyc(4);
        t0 = timebase_lower;
        cyc(20);
        chk(timebase_lower - t0, 16'h0000);
        pin(8'h01);
        cyc(3);
        t0 = timebase_lower;
        cyc(20);
        chk(timebase_lower - t0, 16'h0014);
        wr(8'h00, 16'h8042);
        pin(8'h00);
        cyc(3);
        t0 = timebase_lower;
        repeat (5) begin
            pin(8'h01);
            pin(8'h00);
        end
        cyc(6);
        chk(timebase_lower - t0, 16'h0005);
        wr(8'h00, 16'h0000);
    endtask
    task t_split;
        wr(8'h01, 16'h0000);
        wr(8'h02, 16'h0002);
        wr(8'h22, 16'h0001);
        wr(8'h00, 16'h8000);
        cyc(5);
        n = n_dma;
        cyc(30);
        chk(n_dma - n, 10);
        chk(irq, 1'b1);
        wr(8'h00, 16'h0000);
        wr(8'h21, 16'h0001);
        rdchk(8'h20, 16'h0000);
    endtask
    task t_join;
        wr(8'h00, 16'h0008);
        wr(8'h04, 16'h8030);
        wr(8'h01, 16'hFFFE);
        wr(8'h05, 16'h0000);
        wr(8'h02, 16'h0001);
        wr(8'h06, 16'h0001);
        wr(8'h22, 16'h0002);
        n = n_adc1;
        m = n_dma;
        wr(8'h00, 16'h8008);
        cyc(10);
        chk(n_adc1 - n, 1);
        chk(n_dma - m, 1);
        @(posedge clk);
        cpu_idle <= 1'b1;
        cyc(2);
        t0 = timebase_lower;
        cyc(8);
        chk(timebase_lower - t0, 16'h0008);
        @(posedge clk);
        cpu_idle <= 1'b0;
        cyc(1);
        chk(timebase_upper, 16'h0000);
        rdchk(8'h20, 16'h0002);
        wr(8'h22, 16'h0000);
        chk(irq, 1'b0);
        wr(8'h22, 16'h0002);
        chk(irq, 1'b1);
        wr(8'h00, 16'h0000);
        wr(8'h21, 16'h0002);
        chk(irq, 1'b0);
        chk(n_adc2, 0);
    endtask
    task t_pair1;
        wr(8'h0E, 16'h0003);
        wr(8'h0C, 16'hA000);
        cyc(5);
        n = n_adc2;
        m = n_dma;
        cyc(40);
        chk(n_adc2 - n, 10);
        chk(n_dma - m, 0);
        @(posedge clk);
        cpu_idle <= 1'b1;
        cyc(3);
        n = n_adc2;
        cyc(20);
        chk(n_adc2 - n, 0);
        @(posedge clk);
        cpu_idle <= 1'b0;
        wr(8'h0C, 16'h0000);
    endtask
    task end_of_test;
        $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        bus_req = '0;
        external_clock_pin = 8'h00;
        cpu_idle = 1'b0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_prescale;
        t_gate;
        t_split;
        t_join;
        t_pair1;
        end_of_test;
    end
    // The whole run needs about 1700 cycles, so this only trips on a hang.
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_of_test;
    end
endmodule

bind pair_timers pair_timers_asserts pair_timers_asserts_i (.clk(clk), .rstn(rstn),
    .bus_req(bus_req), .rdata(rdata), .external_clock_pin(external_clock_pin),
    .cpu_idle(cpu_idle), .irq(irq), .adc1_trigger(adc1_trigger), .adc2_trigger(adc2_trigger),
    .dma_request(dma_request), .timebase_lower(timebase_lower),
    .timebase_upper(timebase_upper));
